//--- hw/bram_map.svh
/*
 * Named constants for the dual-port block memory: geometry, register
 * offsets, reset values and bus response codes.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef BRAM_MAP_SVH
`define BRAM_MAP_SVH

// ----------------------------------------------------------------------
// Geometry: 1024 words of 18 bits make one 18 Kb block
// ----------------------------------------------------------------------
`define BRAM_ADDR_W 10
`define BRAM_DATA_W 18
`define BRAM_DEPTH 1024
`define BRAM_PORTS 2

// ----------------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------------
`define BRAM_AXI_ADDR_W 8
`define BRAM_WORD_MASK 8'hFC
`define BRAM_CTRL_OFS 8'h00
`define BRAM_DOUT_A_OFS 8'h04
`define BRAM_DOUT_B_OFS 8'h08
`define BRAM_OPCNT_OFS 8'h0C
`define BRAM_CTRL_RST 8'h00
`define BRAM_CTRL_W 8
`define BRAM_INV_W 4
`define BRAM_OPCNT_W 32
`define BRAM_RESP_OKAY 2'h0
`define BRAM_RESP_SLVERR 2'h2

`endif

//--- hw/bram_pkg.sv
/*
 * Types shared by the dual-port block memory and its port control.
 * Assumes bram_map.svh is on the include path.
 */
`include "bram_map.svh"

package bram_pkg;

    // ------------------------------------------------------------------
    // Pins of one memory port, as seen from user logic
    // ------------------------------------------------------------------
    typedef struct packed {
        logic portClk;
        logic portEn;
        logic portWe;
        logic outputPresetStrobe;
        logic [`BRAM_ADDR_W-1:0] portAddr;
        logic [`BRAM_DATA_W-1:0] portDin;
    } port_pins_t;

    // Polarity inversion, one bit per control input
    typedef struct packed {
        logic invClk;
        logic invEn;
        logic invWe;
        logic invPreset;
    } port_invert_t;

    // One resolved operation at an active, enabled port clock edge
    typedef struct packed {
        logic valid;
        logic write;
        logic preset;
        logic [`BRAM_ADDR_W-1:0] addr;
        logic [`BRAM_DATA_W-1:0] din;
    } port_op_t;

endpackage : bram_pkg

//--- hw/bram_port_ctrl.sv
/*
 * Control front end of one memory port: synchronises the port pins,
 * applies the polarity inversion of every control and turns the active
 * port clock edge into a one-cycle operation.
 * Assumes ref_clk runs well above twice the port clock rate.
 */
`timescale 1ns/1ps

module bram_port_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Port pins and polarity
    input wire bram_pkg::port_pins_t pins,
    input wire bram_pkg::port_invert_t invert,
    // Resolved operation
    output bram_pkg::port_op_t op
);

    bram_pkg::port_pins_t sync1_reg;
    bram_pkg::port_pins_t sync2_reg;
    logic clkLast_reg;
    bram_pkg::port_op_t op_reg;
    logic clkNow;
    logic clkPrev;

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    // All pins share one two-stage path, so data and clock stay aligned
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            clkLast_reg <= 1'b0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            clkLast_reg <= sync2_reg.portClk;
        end
    end

    // ------------------------------------------------------------------
    // Edge and control decode
    // ------------------------------------------------------------------
    // Inverting the clock selects the falling pin edge as active
    assign clkNow = sync2_reg.portClk ^ invert.invClk;
    assign clkPrev = clkLast_reg ^ invert.invClk;

    // One clock serves both reads and writes of this port
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_reg <= '0;
        end else begin
            op_reg.valid <= clkNow & ~clkPrev
                & (sync2_reg.portEn ^ invert.invEn);
            op_reg.write <= sync2_reg.portWe ^ invert.invWe;
            op_reg.preset <= sync2_reg.outputPresetStrobe
                ^ invert.invPreset;
            op_reg.addr <= sync2_reg.portAddr;
            op_reg.din <= sync2_reg.portDin;
        end
    end

    assign op = op_reg;

endmodule : bram_port_ctrl

//--- hw/dual_port_bram.sv
/*
 * Dual-port 18 Kb block memory with hold-output write behaviour, a
 * preset of each output register and an AXI4-Lite control slave.
 * Assumes each port's pins come from user logic outside ref_clk's
 * domain and that the port clock is slow against ref_clk; an AXI4-Lite
 * master on ref_clk reaches the registers.
 */
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "bram_map.svh"

module dual_port_bram #(
    parameter int ADDR_W = `BRAM_ADDR_W,
    parameter int DATA_W = `BRAM_DATA_W,
    parameter int DEPTH = `BRAM_DEPTH,
    parameter logic [`BRAM_DATA_W-1:0] START_OUT_A = '0,
    parameter logic [`BRAM_DATA_W-1:0] START_OUT_B = '0,
    parameter logic [`BRAM_DATA_W-1:0] OUTPUT_PRESET_VALUE_A = '0,
    parameter logic [`BRAM_DATA_W-1:0] OUTPUT_PRESET_VALUE_B = '0,
    parameter logic [`BRAM_DEPTH*`BRAM_DATA_W-1:0] CONTENT_PRELOAD = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Memory ports, index 0 is port A and 1 is port B
    input wire bram_pkg::port_pins_t portPins [`BRAM_PORTS],
    output logic [`BRAM_DATA_W-1:0] portDout [`BRAM_PORTS],
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`BRAM_AXI_ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`BRAM_AXI_ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam logic [`BRAM_DATA_W-1:0] START_OUT [`BRAM_PORTS] =
        '{START_OUT_A, START_OUT_B};
    localparam logic [`BRAM_DATA_W-1:0] PRESET_VAL [`BRAM_PORTS] =
        '{OUTPUT_PRESET_VALUE_A, OUTPUT_PRESET_VALUE_B};

    logic [DATA_W-1:0] mem_reg [DEPTH];
    logic [DATA_W-1:0] dout_reg [`BRAM_PORTS];
    bram_pkg::port_op_t ops [`BRAM_PORTS];
    bram_pkg::port_invert_t invert [`BRAM_PORTS];
    logic [`BRAM_CTRL_W-1:0] ctrl_reg;
    logic [`BRAM_OPCNT_W-1:0] opCount_reg;
    logic [`BRAM_OPCNT_W-1:0] opCount_next;

    logic awReady_reg;
    logic wReady_reg;
    logic [`BRAM_AXI_ADDR_W-1:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic bValid_reg;
    logic [1:0] bResp_reg;
    logic arReady_reg;
    logic rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0] rResp_reg;
    logic writeGo;
    logic [`BRAM_AXI_ADDR_W-1:0] wrWord;
    logic [`BRAM_AXI_ADDR_W-1:0] rdWord;

    // ------------------------------------------------------------------
    // Port front ends
    // ------------------------------------------------------------------
    // Each port has its own pins, inversion field and decode
    generate
        for (genvar p = 0; p < `BRAM_PORTS; p++) begin : g_port
            assign invert[p] =
                ctrl_reg[p*`BRAM_INV_W +: `BRAM_INV_W];
            bram_port_ctrl u_ctrl (
                .ref_clk(ref_clk),
                .rst(rst),
                .pins(portPins[p]),
                .invert(invert[p]),
                .op(ops[p])
            );

            // Output register: preset first, then read, and a write holds
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    dout_reg[p] <= START_OUT[p];
                end else if (ops[p].valid) begin
                    if (ops[p].preset) begin
                        dout_reg[p] <= PRESET_VAL[p];
                    end else if (!ops[p].write) begin
                        dout_reg[p] <= mem_reg[ops[p].addr];
                    end
                end
            end

            assign portDout[p] = dout_reg[p];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Memory array
    // ------------------------------------------------------------------
    // Reset reloads the preload image; port B is applied last, so it wins
    // a same-address collision. Wider or deeper memories are built by
    // placing several blocks side by side outside this module.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= CONTENT_PRELOAD[i*DATA_W +: DATA_W];
            end
        end else begin
            for (int p = 0; p < `BRAM_PORTS; p++) begin
                if (ops[p].valid && ops[p].write) begin
                    mem_reg[ops[p].addr] <= ops[p].din;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Operation counter
    // ------------------------------------------------------------------
    // Counts enabled edges of both ports; wraps silently
    always_comb begin
        opCount_next = opCount_reg;
        for (int p = 0; p < `BRAM_PORTS; p++) begin
            if (ops[p].valid) begin
                opCount_next = opCount_next + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            opCount_reg <= '0;
        end else begin
            opCount_reg <= opCount_next;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    // Address and data are caught independently in either order
    assign writeGo = !awReady_reg && !wReady_reg && !bValid_reg;
    assign wrWord = awAddr_reg & `BRAM_WORD_MASK;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            awReady_reg <= 1'b1;
            awAddr_reg <= '0;
        end else if (awReady_reg && s_axi_awvalid) begin
            awReady_reg <= 1'b0;
            awAddr_reg <= s_axi_awaddr;
        end else if (bValid_reg && s_axi_bready) begin
            awReady_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wReady_reg <= 1'b1;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end else if (wReady_reg && s_axi_wvalid) begin
            wReady_reg <= 1'b0;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
        end else if (bValid_reg && s_axi_bready) begin
            wReady_reg <= 1'b1;
        end
    end

    // Response follows once both halves are held
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bValid_reg <= 1'b0;
            bResp_reg <= `BRAM_RESP_OKAY;
        end else if (writeGo) begin
            bValid_reg <= 1'b1;
            if (wrWord == `BRAM_CTRL_OFS) begin
                bResp_reg <= `BRAM_RESP_OKAY;
            end else if (wrWord == `BRAM_DOUT_A_OFS
                    || wrWord == `BRAM_DOUT_B_OFS
                    || wrWord == `BRAM_OPCNT_OFS) begin
                bResp_reg <= `BRAM_RESP_OKAY; // Read-only, write ignored
            end else begin
                bResp_reg <= `BRAM_RESP_SLVERR;
            end
        end else if (bValid_reg && s_axi_bready) begin
            bValid_reg <= 1'b0;
        end
    end

    // Inversion bits; both edge samples use the same invClk, so changing them cannot fake a clock edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `BRAM_CTRL_RST;
        end else if (writeGo && wrWord == `BRAM_CTRL_OFS && wStrb_reg[0]) begin
            ctrl_reg <= wData_reg[`BRAM_CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign rdWord = s_axi_araddr & `BRAM_WORD_MASK;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arReady_reg <= 1'b1;
            rValid_reg <= 1'b0;
            rData_reg <= '0;
            rResp_reg <= `BRAM_RESP_OKAY;
        end else if (arReady_reg && s_axi_arvalid) begin
            arReady_reg <= 1'b0;
            rValid_reg <= 1'b1;
            rResp_reg <= `BRAM_RESP_OKAY;
            rData_reg <= '0;
            unique case (rdWord)
                `BRAM_CTRL_OFS: begin
                    rData_reg[`BRAM_CTRL_W-1:0] <= ctrl_reg;
                end
                `BRAM_DOUT_A_OFS: begin
                    rData_reg[DATA_W-1:0] <= dout_reg[0];
                end
                `BRAM_DOUT_B_OFS: begin
                    rData_reg[DATA_W-1:0] <= dout_reg[1];
                end
                `BRAM_OPCNT_OFS: begin
                    rData_reg <= opCount_reg;
                end
                default: begin
                    rResp_reg <= `BRAM_RESP_SLVERR;
                end
            endcase
        end else if (rValid_reg && s_axi_rready) begin
            rValid_reg <= 1'b0;
            arReady_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = awReady_reg;
    assign s_axi_wready = wReady_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;

endmodule : dual_port_bram

//--- bench/dual_port_bram_sva.sv
/*
 * Checker for the dual-port block memory top: bus answers and the
 * quiet times of the port A output register.
 * Assumes it is bound from the bench top; port A is never inverted.
 */
`timescale 1ns/1ps
`include "bram_map.svh"

module dual_port_bram_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Memory ports
    input wire bram_pkg::port_pins_t portPins [`BRAM_PORTS],
    input wire logic [`BRAM_DATA_W-1:0] portDout [`BRAM_PORTS],
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [`BRAM_AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // --------------------
    // Register bus
    // --------------------
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read data late");
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open too early");
    a_write_busy: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open too early");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr[7:4] != 4'h0
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");

    // --------------------
    // Port A output register
    // --------------------
    a_write_holds: assert property (
        $rose(portPins[0].portClk) && portPins[0].portEn &&
        portPins[0].portWe && !portPins[0].outputPresetStrobe
        |-> $stable(portDout[0]) [*8]) else $error("write moved output");
    a_clk_quiet: assert property (
        $stable(portPins[0].portClk) [*8] |-> $stable(portDout[0]))
        else $error("output moved without clock edge");
    a_en_quiet: assert property (
        !portPins[0].portEn [*8] |-> $stable(portDout[0]))
        else $error("output moved while disabled");
endmodule : dual_port_bram_sva

//--- bench/port_user.sv
/*
 * User logic model for one memory port: drives the pins as levels
 * through its own copy of the polarity inversion.
 * Assumes ref_clk is the design clock and operations are called
 * just after its rising edge.
 */
`timescale 1ns/1ps

module port_user (
    // Clock
    input wire logic ref_clk,
    // Port pins
    output bram_pkg::port_pins_t pins
);
    bram_pkg::port_pins_t lvl = '0;
    bram_pkg::port_invert_t inv = '0;

    // Logical levels reach the pins through the inversion set
    assign pins = lvl ^ {inv, 28'h0000000};

    // One access: set up, hold across the active edge, then release
    task automatic op(input logic en, input logic we, input logic pre,
            input logic [9:0] a, input logic [17:0] d);
        lvl.portEn <= en;
        lvl.portWe <= we;
        lvl.outputPresetStrobe <= pre;
        lvl.portAddr <= a;
        lvl.portDin <= d;
        repeat (3) @(posedge ref_clk);
        lvl.portClk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Released address and data show inverted values so stale data cannot match; the control levels drop to 0
        lvl <= {4'h0, ~a, ~d};
        repeat (6) @(posedge ref_clk);
    endtask : op

    // Park the clock level and load a new inversion set
    task automatic park(input logic c, input bram_pkg::port_invert_t n);
        lvl.portClk <= c;
        inv <= n;
        repeat (4) @(posedge ref_clk);
    endtask : park
endmodule : port_user

//--- bench/dual_port_bram_bench.sv
/*
 * Self-checking bench for the dual-port block memory: two user logic
 * models on the ports and a register bus master.
 * Assumes the design files and bram_map.svh are compiled first.
 */
`timescale 1ns/1ps
`include "bram_map.svh"

module dual_port_bram_bench;
    localparam logic [17:0] SA = 18'h15A5A;
    localparam logic [17:0] SB = 18'h0C3C3;
    localparam logic [17:0] PA = 18'h2F00F;
    localparam logic [17:0] PB = 18'h000FF;
    localparam logic [17:0] W1 = 18'h3C0F1;
    localparam logic [17:0] W3 = 18'h1B2D4;
    localparam logic [18431:0] PRE = 18432'(18'h12345) << 90;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    bram_pkg::port_pins_t portPins [`BRAM_PORTS];
    logic [17:0] portDout [`BRAM_PORTS];
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int errTotal = 0, numChecks = 0, cycles = 0;
    logic [31:0] ops = 32'h00000000;

    dual_port_bram #(.START_OUT_A(SA), .START_OUT_B(SB),
        .OUTPUT_PRESET_VALUE_A(PA), .OUTPUT_PRESET_VALUE_B(PB),
        .CONTENT_PRELOAD(PRE)) dual_port_bram_inst (
        .ref_clk, .rst, .portPins, .portDout,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    port_user userA (.ref_clk, .pins(portPins[0]));
    port_user userB (.ref_clk, .pins(portPins[1]));

    // 100 MHz clock, and a ceiling far above the expected run
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            conclude();
        end
    end

    // --------------------
    // Checking and bus tasks
    // --------------------
    task automatic check(input logic [33:0] s, input logic [33:0] e);
        numChecks++;
        if (s !== e) begin
            errTotal++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : check

    task automatic dchk(input int p, input logic [17:0] e);
        check(34'(portDout[p]), 34'(e));
    endtask : dchk

    task automatic conclude;
        if (errTotal == 0 && numChecks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // Both channels offered together, each dropped once taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(34'(s_axi_bresp), 34'(r));
        @(posedge ref_clk);
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check({s_axi_rresp, s_axi_rdata}, {r, e});
        @(posedge ref_clk);
    endtask : axiRead

    // Port access through one model, counting enabled edges
    task automatic portOp(input int p, input logic en, input logic we,
            input logic pre, input logic [9:0] a, input logic [17:0] d);
        if (en) ops++;
        if (p == 0) userA.op(en, we, pre, a, d);
        else userB.op(en, we, pre, a, d);
    endtask : portOp

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        dchk(0, SA);
        dchk(1, SB);
        axiRead(8'h00, 32'h00000000, 2'h0);
        axiRead(8'h10, 32'h00000000, 2'h2);
        portOp(0, 1'b1, 1'b0, 1'b0, 10'h005, 18'h00000);
        dchk(0, 18'h12345);
        portOp(0, 1'b1, 1'b1, 1'b0, 10'h003, W1);
        dchk(0, 18'h12345);
        portOp(1, 1'b1, 1'b0, 1'b0, 10'h003, 18'h00000);
        dchk(1, W1);
        portOp(0, 1'b0, 1'b1, 1'b0, 10'h003, 18'h3FFFF);
        portOp(0, 1'b0, 1'b0, 1'b1, 10'h003, 18'h00000);
        dchk(0, 18'h12345);
        portOp(0, 1'b1, 1'b0, 1'b0, 10'h003, 18'h00000);
        dchk(0, W1);
        portOp(0, 1'b1, 1'b0, 1'b1, 10'h003, 18'h00000);
        dchk(0, PA);
        portOp(1, 1'b1, 1'b0, 1'b1, 10'h003, 18'h00000);
        dchk(1, PB);
        axiRead(8'h04, {14'h0000, PA}, 2'h0);
        axiWrite(8'h0C, 32'h000000FF, 2'h0);
        axiRead(8'h0C, ops, 2'h0);
        // A second reset in mid-run restores both starting values
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        dchk(0, SA);
        dchk(1, SB);
        // Port B fully inverted; clock parked so no enabled edge leaks
        userB.park(1'b1, 4'h0);
        axiWrite(8'h00, 32'h000000F0, 2'h0);
        // Only the low strobe reaches the inversion bits
        s_axi_wstrb <= 4'hE;
        axiWrite(8'h00, 32'h00000000, 2'h0);
        s_axi_wstrb <= 4'hF;
        axiRead(8'h00, 32'h000000F0, 2'h0);
        axiWrite(8'h20, 32'h00000000, 2'h2);
        userB.park(1'b0, 4'hF);
        portOp(1, 1'b1, 1'b1, 1'b0, 10'h3FF, W3);
        dchk(1, SB);
        portOp(1, 1'b1, 1'b0, 1'b0, 10'h3FF, 18'h00000);
        dchk(1, W3);
        portOp(0, 1'b1, 1'b0, 1'b0, 10'h3FF, 18'h00000);
        dchk(0, W3);
        axiRead(8'h08, {14'h0000, W3}, 2'h0);
        axiRead(8'h0C, 32'h00000003, 2'h0);
        conclude();
    end
endmodule : dual_port_bram_bench

bind dual_port_bram dual_port_bram_sva chk (
    .ref_clk, .rst, .portPins, .portDout,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);
